// >>> design/wsm_defines.svh
// constants of the additional-information message sequencer
`ifndef WSM_DEFINES_SVH
`define WSM_DEFINES_SVH

`define WSM_MEAN_P2P 2'h0
`define WSM_MEAN_SPECIAL 2'h2
`define WSM_MEAN_CHAN 2'h1
`define WSM_MEAN_TEMP 2'h3

`define WSM_DATA_MOVEMENT 3'h0
`define WSM_DATA_PAIR_AB 3'h1
`define WSM_DATA_PAIR_BC 3'h2
`define WSM_DATA_PAIR_AC 3'h3
`define WSM_DATA_DISTURB 3'h4

`define WSM_DATA_CNT_EXCEEDED 3'h1
`define WSM_DATA_WRITE_REQ 3'h2
`define WSM_DATA_OVERTEMP 3'h4

`define WSM_SEQ_P2P_POS 5'h09
`define WSM_SEQ_LAST_POS 5'h13
`define WSM_SEQ_RST 5'h00

`define WSM_ANN_LAST 2'h2
`define WSM_ANN_RST 2'h0

`define WSM_MAX_WRITES 8'h10
`define WSM_WCNT_RST 8'h00
`define WSM_WORD_RST 9'h000

`endif

// >>> design/wsm_pkg.sv
// types of the additional-information message sequencer
package wsm_pkg;

    typedef enum logic [1:0]
    {
        WSM_KIND_MOVEMENT = 2'h0,
        WSM_KIND_SPEED_ONLY = 2'h1,
        WSM_KIND_SPEED_DIR = 2'h2,
        WSM_KIND_STANDSTILL = 2'h3
    } wsm_kind_t;

    typedef enum logic [1:0]
    {
        WSM_PAIR_NONE = 2'h0,
        WSM_PAIR_AB = 2'h1,
        WSM_PAIR_BC = 2'h2,
        WSM_PAIR_AC = 2'h3
    } wsm_pair_t;

    // one message request from the sensing front end
    typedef struct packed
    {
        wsm_kind_t kind;
        wsm_pair_t pair;
        logic rot_rev;
        logic disturb;
        logic air_gap_low;
    } wsm_req_t;

    // bit 8 down to bit 0 of one message
    typedef struct packed
    {
        logic parity;
        logic [2:0] data;
        logic rotation_sense_bit;
        logic direction_valid_flag;
        logic meaning_code_high;
        logic meaning_code_low;
        logic air_gap_reserve_flag;
    } wsm_msg_t;

endpackage : wsm_pkg

// >>> design/wsm_sequencer.sv
// message content builder with best-channel self-write control
`timescale 1ns/1ps
`include "wsm_defines.svh"

// Notes on behaviour
// - direction bit reports device-referenced rotation sense
// - meaning and data bits identify used pair
// - pair letter order gives positive direction
// - self-write only normal mode, temperature window
// - channel mismatch in normal mode sets programming request flag
// - three standstill announcements, restart if moving
// - write starts only after third announcement
// - messages continue during nonvolatile write
// - programming request flag cleared by reset
// - completed writes counted up to maximum
// - limit reached sends counter exceeded event
// - limit reached ignores stored channel at startup
// - no stored channel evaluates like limit
// - validity flag per message type
// - calibration messages carry channel word
// - nine channel, peak, nine channel, temperature
// - sequence position restarts at reset
// - channel word carries requesting channel code
// - peak word carries amplitude class
// - channel codes movement, pairs, disturbance
// - fixed bit layout with even parity
// - direction bit zero positive, one negative
// - special event codes for write events
module wsm_sequencer
    import wsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic msg_req,
    input wire wsm_req_t req_info,
    input wire logic normal_mode,
    input wire logic [2:0] p2p_class,
    input wire logic [2:0] temp_class,
    input wire logic overtemp_detect,
    input wire logic chan_mismatch,
    input wire logic temp_in_window,
    input wire logic stored_valid,
    input wire logic [7:0] stored_write_cnt,
    input wire logic nvm_done,
    output wsm_msg_t msg_word,
    output logic msg_valid,
    output logic nvm_write_start,
    output logic nvm_busy,
    output logic prog_req,
    output logic [7:0] write_cnt,
    output logic ignore_stored
);

    logic [4:0] seq_r;
    logic [1:0] ann_r;
    logic prog_req_r;
    logic busy_r;
    logic start_r;
    logic otemp_r;
    logic gdr_last_r;
    logic cnt_loaded_r;
    logic ignore_r;
    logic [7:0] wcnt_r;
    wsm_msg_t word_r;
    logic valid_r;

    wire take = msg_req & clk_en;
    wire is_still = req_info.kind == WSM_KIND_STANDSTILL;
    wire limit_hit = wcnt_r >= `WSM_MAX_WRITES;
    wire disturb_run = normal_mode & req_info.disturb;
    wire is_p2p_pos = seq_r == `WSM_SEQ_P2P_POS;
    wire is_temp_pos = seq_r == `WSM_SEQ_LAST_POS;
    // announcement while self-write is permitted or the write limit is reached
    wire announce = normal_mode & is_still & prog_req_r & ~busy_r & (limit_hit | temp_in_window);
    wire third_ann = announce & ~limit_hit & (ann_r == `WSM_ANN_LAST);
    wire send_otemp = normal_mode & is_temp_pos & otemp_r & ~announce;

    // channel code from the requesting pair
    // pair in data bits
    wire [2:0] chan_code = disturb_run ? `WSM_DATA_DISTURB :
                           (req_info.pair == WSM_PAIR_AB) ? `WSM_DATA_PAIR_AB :
                           (req_info.pair == WSM_PAIR_BC) ? `WSM_DATA_PAIR_BC :
                           (req_info.pair == WSM_PAIR_AC) ? `WSM_DATA_PAIR_AC :
                           `WSM_DATA_MOVEMENT;

    // word selection by mode, position and events
    // calibration channel word
    wire [1:0] mean_sel = ~normal_mode ? `WSM_MEAN_CHAN :
                          (announce | send_otemp) ? `WSM_MEAN_SPECIAL :
                          is_p2p_pos ? `WSM_MEAN_P2P :
                          is_temp_pos ? `WSM_MEAN_TEMP :
                          `WSM_MEAN_CHAN;
    wire [2:0] special_code = ~announce ? `WSM_DATA_OVERTEMP :
                              limit_hit ? `WSM_DATA_CNT_EXCEEDED : `WSM_DATA_WRITE_REQ;
    wire [2:0] data_sel = (mean_sel == `WSM_MEAN_SPECIAL) ? special_code :
                          (mean_sel == `WSM_MEAN_P2P) ? p2p_class :
                          (mean_sel == `WSM_MEAN_TEMP) ? temp_class : chan_code;

    // validity by message type; standstill repeats the last
    // validity per type
    wire gdr_sel = ~normal_mode | disturb_run ? 1'b0 :
                   (req_info.kind == WSM_KIND_SPEED_DIR) ? 1'b1 :
                   is_still ? gdr_last_r : 1'b0;

    wire [7:0] low_bits = {data_sel, req_info.rot_rev, gdr_sel, mean_sel[1], mean_sel[0], req_info.air_gap_low};
    wire [8:0] word_nxt = {^low_bits, low_bits};

    wire [4:0] seq_nxt = is_temp_pos ? `WSM_SEQ_RST : 5'(seq_r + 5'h01);
    wire [1:0] ann_nxt = announce ? 2'(ann_r + 2'h1) : `WSM_ANN_RST;

    // message word register
    // device referenced sense
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            word_r <= `WSM_WORD_RST;
            valid_r <= 1'b0;
            gdr_last_r <= 1'b0;
        end
        else if (clk_en)
        begin
            valid_r <= msg_req;
            if (msg_req)
            begin
                word_r <= word_nxt;
                gdr_last_r <= gdr_sel;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            seq_r <= `WSM_SEQ_RST;
        else if (take & normal_mode)
            seq_r <= seq_nxt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ann_r <= `WSM_ANN_RST;
        else if (take & normal_mode)
            ann_r <= third_ann ? `WSM_ANN_RST : ann_nxt;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            prog_req_r <= 1'b0;
        else if (clk_en)
        begin
            if (normal_mode & chan_mismatch)
                prog_req_r <= 1'b1;
            else if (take & third_ann)
                prog_req_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            start_r <= 1'b0;
            busy_r <= 1'b0;
        end
        else if (clk_en)
        begin
            start_r <= take & third_ann;
            if (take & third_ann)
                busy_r <= 1'b1;
            else if (nvm_done)
                busy_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            wcnt_r <= `WSM_WCNT_RST;
            cnt_loaded_r <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_loaded_r <= 1'b1;
            if (~cnt_loaded_r)
                wcnt_r <= stored_write_cnt;
            else if (busy_r & nvm_done & ~limit_hit)
                wcnt_r <= 8'(wcnt_r + 8'h01);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            ignore_r <= 1'b0;
        else if (clk_en)
            ignore_r <= limit_hit | ~stored_valid;
    end

    // overtemperature stays pending until its event word is sent, set wins
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            otemp_r <= 1'b0;
        else if (clk_en)
        begin
            if (overtemp_detect)
                otemp_r <= 1'b1;
            else if (take & send_otemp)
                otemp_r <= 1'b0;
        end
    end

    assign msg_word = word_r;
    assign msg_valid = valid_r;
    assign nvm_write_start = start_r;
    assign nvm_busy = busy_r;
    assign prog_req = prog_req_r;
    assign write_cnt = wcnt_r;
    assign ignore_stored = ignore_r;

    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    a_dir_bit_follow: assert property (take |=> msg_word.rotation_sense_bit == $past(req_info.rot_rev))
        else $error("direction bit does not follow rotation sense");
    a_parity_even: assert property (msg_valid |-> ^msg_word == 1'b0)
        else $error("message parity is not even");
    a_calib_chan: assert property (take & ~normal_mode |=> {msg_word.meaning_code_high, msg_word.meaning_code_low} == 2'h1)
        else $error("calibration message without channel word");
    a_pair_ab_code: assert property (take & ~normal_mode & req_info.pair == WSM_PAIR_AB |=> msg_word.data == 3'h1)
        else $error("pair AB code wrong");
    a_gdr_speed_dir: assert property (take & normal_mode & ~req_info.disturb & req_info.kind == WSM_KIND_SPEED_DIR
                                      |=> msg_word.direction_valid_flag)
        else $error("speed and direction message without valid flag");
    a_gdr_movement: assert property (take & req_info.kind == WSM_KIND_MOVEMENT |=> ~msg_word.direction_valid_flag)
        else $error("movement message with valid flag");
    a_seq_wrap: assert property (take & normal_mode & seq_r == 5'h13 |=> seq_r == 5'h00)
        else $error("sequence does not wrap after twenty");
    a_seq_p2p_word: assert property (take & normal_mode & seq_r == 5'h09 & ~announce
                                     |=> {msg_word.meaning_code_high, msg_word.meaning_code_low} == 2'h0)
        else $error("tenth message not peak word");
    a_write_third: assert property (nvm_write_start |-> $past(take) && $past(ann_r) == 2'h2)
        else $error("write started without third announcement");
    a_exceed_event: assert property (take & announce & limit_hit |=> msg_word.data == 3'h1)
        else $error("counter exceeded event missing");
    a_flag_set: assert property (clk_en & normal_mode & chan_mismatch |=> prog_req)
        else $error("programming request flag not set");
    a_wreq_event: assert property (take & announce & ~limit_hit |=> msg_word.data == 3'h2)
        else $error("write required event missing");
    a_otemp_event: assert property (take & send_otemp
                                    |=> {msg_word.meaning_code_high, msg_word.meaning_code_low} == 2'h2
                                    && msg_word.data == 3'h4)
        else $error("overtemperature event missing");
    a_busy_flow: assert property (take & nvm_busy |=> msg_valid)
        else $error("message lost during write");
    a_write_window: assert property (take & ~(normal_mode & temp_in_window) |=> ~nvm_write_start)
        else $error("write started outside permitted window");
    a_ignore_limit: assert property (clk_en & (limit_hit | ~stored_valid) |=> ignore_stored)
        else $error("stored channel not ignored");
    a_temp_word: assert property (take & normal_mode & seq_r == 5'h13 & ~announce & ~send_otemp
                                  |=> {msg_word.meaning_code_high, msg_word.meaning_code_low} == 2'h3)
        else $error("twentieth message not temperature word");
    a_speed_only_gdr: assert property (take & req_info.kind == WSM_KIND_SPEED_ONLY
                                       |=> ~msg_word.direction_valid_flag)
        else $error("speed only message with valid flag");
    a_flag_cleared: assert property (take & third_ann & ~(normal_mode & chan_mismatch) |=> ~prog_req)
        else $error("programming request flag kept after write start");
    a_p2p_data: assert property (take & normal_mode & seq_r == 5'h09 & ~announce
                                 |=> msg_word.data == $past(p2p_class))
        else $error("peak word data wrong");

    c_third_announce: cover property (take & third_ann ##1 nvm_write_start);
    c_temp_word: cover property (take & normal_mode & is_temp_pos & ~announce & ~send_otemp);
    c_exceeded: cover property (take & announce & limit_hit);
    c_busy_msg: cover property (nvm_busy & take);
    c_overtemp_word: cover property (take & send_otemp);

endmodule : wsm_sequencer

// >>> dv/wsm_ecu_model.sv
// control unit model that decodes sequencer messages
`timescale 1ns/1ps
`include "wsm_defines.svh"
module wsm_ecu_model
    import wsm_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic msg_valid,
    input wire wsm_msg_t msg_word,
    output logic parity_ok,
    output logic veh_fwd
);
    logic flip_r;
    logic [2:0] pair_r;
    wire is_chan = ({msg_word.meaning_code_high, msg_word.meaning_code_low} == `WSM_MEAN_CHAN);
    // movement and disturbance words name no pair
    wire is_pair = is_chan && msg_word.data != `WSM_DATA_MOVEMENT && msg_word.data != `WSM_DATA_DISTURB;
    // even count over all nine bits
    assign parity_ok = ~^msg_word;
    assign veh_fwd = ~msg_word.rotation_sense_bit ^ flip_r;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            flip_r <= 1'b0;
            pair_r <= 3'h0;
        end
        else if (msg_valid && is_pair)
        begin
            pair_r <= msg_word.data;
            if (pair_r == `WSM_DATA_PAIR_BC && msg_word.data == `WSM_DATA_PAIR_AB)
                flip_r <= ~flip_r;
            else if (pair_r == `WSM_DATA_PAIR_AB && msg_word.data == `WSM_DATA_PAIR_BC)
                flip_r <= ~flip_r;
        end
    end
endmodule : wsm_ecu_model

// >>> dv/wsm_sequencer_tb.sv
// self-checking bench of the message sequencer
`timescale 1ns/1ps
`include "wsm_defines.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module wsm_sequencer_tb
    import wsm_pkg::*;
;
    logic ref_clk = 1'b0, sys_rst = 1'b1, msg_req = 1'b0, normal_mode = 1'b0, chan_mismatch = 1'b0;
    logic temp_in_window = 1'b1, stored_valid = 1'b1, nvm_done = 1'b0;
    logic [2:0] p2p_class = 3'h5, temp_class = 3'h6;
    logic [7:0] stored_write_cnt = 8'h0f;
    wsm_req_t req_info = '0;
    wsm_msg_t msg_word;
    logic msg_valid, nvm_write_start, nvm_busy, prog_req, ignore_stored, parity_ok;
    logic [7:0] write_cnt;
    int miscompares = 0, checked = 0, cycles = 0, pos = 0;
    logic last_gdr = 1'b0;
    logic clk_en = 1'b1, overtemp_detect = 1'b0, otemp_pend = 1'b0;
    wsm_sequencer wsm_sequencer_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .msg_req(msg_req),
        .req_info(req_info), .normal_mode(normal_mode), .p2p_class(p2p_class), .temp_class(temp_class),
        .overtemp_detect(overtemp_detect), .chan_mismatch(chan_mismatch), .temp_in_window(temp_in_window),
        .stored_valid(stored_valid), .stored_write_cnt(stored_write_cnt), .nvm_done(nvm_done),
        .msg_word(msg_word), .msg_valid(msg_valid), .nvm_write_start(nvm_write_start), .nvm_busy(nvm_busy),
        .prog_req(prog_req), .write_cnt(write_cnt), .ignore_stored(ignore_stored));
    wsm_ecu_model wsm_ecu_model_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .msg_valid(msg_valid),
        .msg_word(msg_word), .parity_ok(parity_ok), .veh_fwd());
    initial
    begin
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            final_report();
        end
    end
    task final_report();
        if (miscompares == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report
    task do_reset(input logic [7:0] cnt, input logic sv);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        stored_write_cnt = cnt;
        stored_valid = sv;
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        pos = 0;
        last_gdr = 1'b0;
        otemp_pend = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask : do_reset
    task automatic pulse(ref logic s);
        @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
        @(negedge ref_clk);
    endtask : pulse
    // one request, then the word and the write start
    task send(input wsm_kind_t k, input wsm_pair_t p, input logic [2:0] flags, input logic spec,
        input logic [2:0] sdata, input logic start);
        wsm_msg_t e;
        logic [1:0] m;
        logic [2:0] d;
        logic [2:0] ch;
        ch = (flags[1] && normal_mode) ? `WSM_DATA_DISTURB : p == WSM_PAIR_AB ? `WSM_DATA_PAIR_AB :
            p == WSM_PAIR_BC ? `WSM_DATA_PAIR_BC : p == WSM_PAIR_AC ? `WSM_DATA_PAIR_AC : `WSM_DATA_MOVEMENT;
        {m, d} = spec ? {`WSM_MEAN_SPECIAL, sdata} : !normal_mode ? {`WSM_MEAN_CHAN, ch} :
            pos == 9 ? {`WSM_MEAN_P2P, p2p_class} : pos != 19 ? {`WSM_MEAN_CHAN, ch} :
            otemp_pend ? {`WSM_MEAN_SPECIAL, `WSM_DATA_OVERTEMP} : {`WSM_MEAN_TEMP, temp_class};
        e.air_gap_reserve_flag = flags[0];
        {e.meaning_code_high, e.meaning_code_low} = m;
        e.direction_valid_flag = (!normal_mode || flags[1]) ? 1'b0 : (k == WSM_KIND_STANDSTILL) ? last_gdr :
            (k == WSM_KIND_SPEED_DIR);
        e.rotation_sense_bit = flags[2];
        e.data = d;
        e.parity = ^e[7:0];
        last_gdr = e.direction_valid_flag;
        if (normal_mode && !spec && pos == 19)
            otemp_pend = 1'b0;
        if (normal_mode)
            pos = (pos == 19) ? 0 : pos + 1;
        @(negedge ref_clk);
        msg_req = 1'b1;
        req_info = '{k, p, flags[2], flags[1], flags[0]};
        @(negedge ref_clk);
        msg_req = 1'b0;
        `CHK("msg_valid", 1'b1, msg_valid)
        `CHK("msg_word", e, msg_word)
        `CHK("nvm_write_start", start, nvm_write_start)
        `CHK("parity_ok", 1'b1, parity_ok)
    endtask : send
    initial
    begin
        do_reset(8'h0f, 1'b1);
        `CHK("prog_req", 1'b0, prog_req)
        `CHK("ignore_stored", 1'b0, ignore_stored)
        @(negedge ref_clk);
        clk_en = 1'b0;
        msg_req = 1'b1;
        @(negedge ref_clk);
        msg_req = 1'b0;
        clk_en = 1'b1;
        `CHK("msg_valid", 1'b0, msg_valid)
        send(WSM_KIND_SPEED_ONLY, WSM_PAIR_AB, 3'h5, 1'b0, 3'h0, 1'b0);
        normal_mode = 1'b1;
        for (int i = 0; i < 41; i++)
        begin
            if (i == 25)
            begin
                otemp_pend = 1'b1;
                pulse(overtemp_detect);
            end
            send(WSM_KIND_SPEED_DIR, wsm_pair_t'(i % 3 + 1), 3'(i), 1'b0, 3'h0, 1'b0);
        end
        send(WSM_KIND_SPEED_ONLY, WSM_PAIR_AC, 3'h2, 1'b0, 3'h0, 1'b0);
        send(WSM_KIND_MOVEMENT, WSM_PAIR_NONE, 3'h0, 1'b0, 3'h0, 1'b0);
        send(WSM_KIND_SPEED_DIR, WSM_PAIR_BC, 3'h4, 1'b0, 3'h0, 1'b0);
        pulse(chan_mismatch);
        `CHK("prog_req", 1'b1, prog_req)
        repeat (2) send(WSM_KIND_STANDSTILL, WSM_PAIR_BC, 3'h0, 1'b1, `WSM_DATA_WRITE_REQ, 1'b0);
        send(WSM_KIND_SPEED_DIR, WSM_PAIR_BC, 3'h0, 1'b0, 3'h0, 1'b0);
        repeat (2) send(WSM_KIND_STANDSTILL, WSM_PAIR_BC, 3'h0, 1'b1, `WSM_DATA_WRITE_REQ, 1'b0);
        send(WSM_KIND_STANDSTILL, WSM_PAIR_BC, 3'h0, 1'b1, `WSM_DATA_WRITE_REQ, 1'b1);
        `CHK("nvm_busy", 1'b1, nvm_busy)
        `CHK("prog_req", 1'b0, prog_req)
        send(WSM_KIND_SPEED_DIR, WSM_PAIR_AB, 3'h4, 1'b0, 3'h0, 1'b0);
        pulse(nvm_done);
        `CHK("nvm_busy", 1'b0, nvm_busy)
        `CHK("write_cnt", 8'h10, write_cnt)
        `CHK("ignore_stored", 1'b1, ignore_stored)
        pulse(chan_mismatch);
        send(WSM_KIND_STANDSTILL, WSM_PAIR_AB, 3'h0, 1'b1, `WSM_DATA_CNT_EXCEEDED, 1'b0);
        do_reset(8'h00, 1'b1);
        `CHK("prog_req", 1'b0, prog_req)
        normal_mode = 1'b0;
        pulse(chan_mismatch);
        repeat (3) send(WSM_KIND_STANDSTILL, WSM_PAIR_AC, 3'h0, 1'b0, 3'h0, 1'b0);
        `CHK("prog_req", 1'b0, prog_req)
        normal_mode = 1'b1;
        temp_in_window = 1'b0;
        pulse(chan_mismatch);
        `CHK("prog_req", 1'b1, prog_req)
        repeat (3) send(WSM_KIND_STANDSTILL, WSM_PAIR_AC, 3'h0, 1'b0, 3'h0, 1'b0);
        `CHK("nvm_busy", 1'b0, nvm_busy)
        `CHK("write_cnt", 8'h00, write_cnt)
        do_reset(8'h00, 1'b0);
        `CHK("ignore_stored", 1'b1, ignore_stored)
        final_report();
    end
endmodule : wsm_sequencer_tb
